// File: brwi_host_model.sv
// host processor model: bus transactions, flag reads, interrupt pulse counter
// assumes the interrupt wire is already resolved with its pull-up
`timescale 1ns/1ps
module brwi_host_model #(
    parameter int unsigned KICK_GAP = 500
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic int_n_i,
    input wire logic auto_kick_i,
    input wire logic read_req_i,
    output logic bus_transaction_o,
    output logic flag_read_o,
    output logic [7:0] irq_count_o
);
    logic [15:0] gap_r;
    logic int_n_r;
    logic kick;
    assign kick = auto_kick_i && (gap_r == 16'(KICK_GAP));
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap_r <= 16'h0000;
            int_n_r <= 1'b1;
            bus_transaction_o <= 1'b0;
            flag_read_o <= 1'b0;
            irq_count_o <= 8'h00;
        end else begin
            // kick at half the window so the watchdog never runs out
            gap_r <= (!auto_kick_i || kick) ? 16'h0000 : gap_r + 16'h0001;
            // a flag read is itself a bus transaction
            bus_transaction_o <= kick || read_req_i;
            flag_read_o <= read_req_i;
            int_n_r <= int_n_i;
            if (int_n_r && !int_n_i) begin
                irq_count_o <= irq_count_o + 8'h01;
            end
        end
    end
endmodule

// File: brwi_pkg.sv
// package of constants and types for the button / reset / watchdog / interrupt supervisor
// assumes a single 125 MHz clock domain
// Behaviour
// - action select picks hardware reset, ship mode or nothing after long press
// - long-press expiry with button still low performs chosen action at once
// - warning flag and interrupt raised once press is within warning lead time
// - host may change action mid-press; value at expiry is applied
// - change to hardware reset mid-press is ignored; reset needs whole-press selection
// - with reset-requires-input, reset only if input valid for whole press
// - software power-cycle command starts the same hardware reset sequence
// - digital supply stays on during reset; only system output cycles
// - enabled adapter watchdog resets when no bus transaction within 14 s
// - adapter watchdog disabled after reset; armed only by its enable bit
// - interrupt output active only after valid start-up; none after faulted start
// - interrupt rests released; each event pulls it low for 128 us
// - each interrupt source has a mask; masked events give no pulse
// - unmasking during persisting condition gives no pulse; needs new edge
// - charge-complete flag set on rising edge; charging pauses until resume (no charge control here; only the flag is set)
// - current-limit, voltage-loop, thermal flags set on rising edge of loop activity
// - button flags stay set until read; no new button interrupt before clear
// - timer durations reprogrammed mid-press take effect only after release
// - after ship-mode wake with button held, suppress actions until re-press
package brwi_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned INT_PULSE_US = 128;
    localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WDOG_S = 14;
    localparam longint unsigned WDOG_CYC = longint'(WDOG_S) * CLK_HZ;
    localparam int unsigned MS_CYC = CLK_HZ / 1000;
    localparam int unsigned TMR_W = 16;
    localparam int unsigned NSRC = 7;
    localparam int unsigned SRC_CV = 0;
    localparam int unsigned SRC_DONE = 1;
    localparam int unsigned SRC_IIN = 2;
    localparam int unsigned SRC_VIN = 3;
    localparam int unsigned SRC_THERM = 4;
    localparam int unsigned SRC_WARN = 5;
    localparam int unsigned SRC_WDOG = 6;
    localparam logic [1:0] ACT_RESET_VAL = 2'h0;

    typedef enum logic [1:0] {
        BRWI_ACT_SOFT_POWER_CYCLE_CMD,
        BRWI_ACT_SHIP,
        BRWI_ACT_NONE,
        BRWI_ACT_NONE2
    } brwi_action_e;

    typedef struct packed {
        logic const_voltage;
        logic charge_done;
        logic input_current_limit;
        logic input_voltage_loop;
        logic thermal_foldback;
    } brwi_status_s;
endpackage

// File: brwi_pulse.sv
// one-shot low pulse generator for the open-drain interrupt pin
// assumes triggers are single-cycle pulses on clk_i
`timescale 1ns/1ps
module brwi_pulse #(
    parameter int unsigned LEN = brwi_pkg::INT_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic trig_i,
    output logic active_o
);
    localparam int unsigned CW = $clog2(LEN + 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    initial begin
        if (LEN < 1) $error("pulse length must be at least one cycle");
    end

    // a trigger during a pulse restarts it, so back-to-back events merge
    always_comb begin
        cnt_nxt = cnt_r;
        if (trig_i) begin
            cnt_nxt = CW'(LEN);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign active_o = (cnt_r != '0);
endmodule

// File: brwi_top.sv
// button long-press / soft reset / adapter watchdog / interrupt pulse supervisor
// assumes status inputs and bus activity strobe are synchronous to clk_i; button is a pin
`timescale 1ns/1ps
module brwi_top #(
    parameter longint unsigned WDOG_CYCLES = brwi_pkg::WDOG_CYC,
    parameter int unsigned TICK_CYC = brwi_pkg::MS_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic pushbutton_in_n_i,
    input wire logic [1:0] long_press_action_sel_i,
    input wire logic [brwi_pkg::TMR_W-1:0] long_press_time_i,
    input wire logic [brwi_pkg::TMR_W-1:0] warning_lead_time_i,
    input wire logic reset_requires_input_i,
    input wire logic vin_valid_i,
    input wire logic soft_power_cycle_cmd_i,
    input wire logic adapter_watchdog_enable_i,
    input wire logic bus_transaction_i,
    input wire logic startup_done_i,
    input wire logic startup_fault_i,
    input wire logic ship_wake_i,
    input wire brwi_pkg::brwi_status_s status_i,
    input wire logic [brwi_pkg::NSRC-1:0] irq_mask_i,
    input wire logic flag_read_i,
    output logic reset_warning_flag_o,
    output logic [brwi_pkg::NSRC-1:0] flags_o,
    output logic power_cycle_o,
    output logic ship_mode_o,
    output logic vdd_on_o,
    output logic int_out_o,
    output logic int_oe_b_o
);
    localparam int unsigned TW = brwi_pkg::TMR_W;
    localparam int unsigned NS = brwi_pkg::NSRC;
    localparam int unsigned DW = $clog2(TICK_CYC + 1);
    localparam int unsigned WW = $clog2(WDOG_CYCLES + 1);

    initial begin
        if (TICK_CYC < 1) $error("tick divider must be at least one cycle");
        if (WDOG_CYCLES < 2) $error("watchdog too short");
    end

    // ----------------------------------------
    // button synchroniser and tick divider
    // ----------------------------------------
    logic btn_s1_r;
    logic btn_s2_r;
    logic [DW-1:0] div_r;
    logic [DW-1:0] div_nxt;
    logic tick;

    always_comb begin
        div_nxt = (div_r == DW'(TICK_CYC - 1)) ? '0 : div_r + 1'b1;
    end
    assign tick = (div_r == DW'(TICK_CYC - 1));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            btn_s1_r <= 1'b1;
            btn_s2_r <= 1'b1;
            div_r <= '0;
        end else begin
            btn_s1_r <= pushbutton_in_n_i;
            btn_s2_r <= btn_s1_r;
            div_r <= div_nxt;
        end
    end

    wire logic pressed = !btn_s2_r;

    // ----------------------------------------
    // long press timing
    // ----------------------------------------
    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cnt_nxt;
    logic [TW-1:0] lp_time_r;
    logic [TW-1:0] lp_time_nxt;
    logic [TW-1:0] warn_time_r;
    logic [TW-1:0] warn_time_nxt;
    logic reset_ok_r;
    logic reset_ok_nxt;
    logic expired_r;
    logic expired_nxt;
    logic warned_r;
    logic warned_nxt;
    logic hold_r;
    logic hold_nxt;
    logic pressed_d_r;
    logic warn_evt;
    logic lp_fire;
    logic btn_reset;
    logic btn_ship;
    logic [1:0] act_r;
    logic [1:0] act_nxt;

    wire logic press_start = pressed && !pressed_d_r;
    wire logic [TW-1:0] warn_at = (warn_time_r >= lp_time_r) ? '0 : lp_time_r - warn_time_r;

    always_comb begin
        cnt_nxt = cnt_r;
        lp_time_nxt = lp_time_r;
        warn_time_nxt = warn_time_r;
        reset_ok_nxt = reset_ok_r;
        expired_nxt = expired_r;
        warned_nxt = warned_r;
        hold_nxt = hold_r;
        act_nxt = act_r;
        warn_evt = 1'b0;
        lp_fire = 1'b0;
        if (ship_wake_i && pressed) begin
            hold_nxt = 1'b1;
        end
        if (!pressed) begin
            cnt_nxt = '0;
            expired_nxt = 1'b0;
            warned_nxt = 1'b0;
            hold_nxt = 1'b0;
            lp_time_nxt = long_press_time_i;
            warn_time_nxt = warning_lead_time_i;
        end else begin
            if (press_start || long_press_action_sel_i != 2'(brwi_pkg::BRWI_ACT_SOFT_POWER_CYCLE_CMD)) begin
                act_nxt = long_press_action_sel_i;
            end
            if (press_start) begin
                reset_ok_nxt = (long_press_action_sel_i == 2'(brwi_pkg::BRWI_ACT_SOFT_POWER_CYCLE_CMD))
                    && (!reset_requires_input_i || vin_valid_i);
            end else if (long_press_action_sel_i != 2'(brwi_pkg::BRWI_ACT_SOFT_POWER_CYCLE_CMD)
                    || (reset_requires_input_i && !vin_valid_i)) begin
                reset_ok_nxt = 1'b0;
            end
            if (tick && !expired_r && !hold_r && !hold_nxt) begin
                cnt_nxt = cnt_r + 1'b1;
                if (!warned_r && cnt_nxt >= warn_at && cnt_nxt < lp_time_r) begin
                    warned_nxt = 1'b1;
                    warn_evt = 1'b1;
                end
                if (cnt_nxt >= lp_time_r) begin
                    expired_nxt = 1'b1;
                    lp_fire = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
            lp_time_r <= '1;
            warn_time_r <= '0;
            reset_ok_r <= 1'b0;
            expired_r <= 1'b0;
            warned_r <= 1'b0;
            hold_r <= 1'b0;
            act_r <= brwi_pkg::ACT_RESET_VAL;
            pressed_d_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            lp_time_r <= lp_time_nxt;
            warn_time_r <= warn_time_nxt;
            reset_ok_r <= reset_ok_nxt;
            expired_r <= expired_nxt;
            warned_r <= warned_nxt;
            hold_r <= hold_nxt;
            act_r <= act_nxt;
            pressed_d_r <= pressed;
        end
    end

    // held action follows host changes; a switch to reset mid-press keeps the old action
    assign btn_reset = lp_fire && reset_ok_nxt
        && act_nxt == 2'(brwi_pkg::BRWI_ACT_SOFT_POWER_CYCLE_CMD);
    assign btn_ship = lp_fire
        && act_nxt == 2'(brwi_pkg::BRWI_ACT_SHIP);

    // ----------------------------------------
    // adapter watchdog
    // ----------------------------------------
    logic [WW-1:0] wd_r;
    logic [WW-1:0] wd_nxt;
    logic wd_run_r;
    logic wd_run_nxt;
    logic vin_d_r;
    logic wd_fire;

    always_comb begin
        wd_nxt = wd_r;
        wd_run_nxt = wd_run_r;
        wd_fire = 1'b0;
        if (!adapter_watchdog_enable_i || !vin_valid_i) begin
            wd_run_nxt = 1'b0;
            wd_nxt = '0;
        end else if (vin_valid_i && !vin_d_r) begin
            wd_run_nxt = 1'b1;
            wd_nxt = '0;
        end else if (wd_run_r) begin
            if (bus_transaction_i) begin
                wd_run_nxt = 1'b0;
            end else if (wd_r == WW'(WDOG_CYCLES - 1)) begin
                wd_run_nxt = 1'b0;
                wd_fire = 1'b1;
            end else begin
                wd_nxt = wd_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wd_r <= '0;
            wd_run_r <= 1'b0;
            vin_d_r <= 1'b0;
        end else begin
            wd_r <= wd_nxt;
            wd_run_r <= wd_run_nxt;
            vin_d_r <= vin_valid_i;
        end
    end

    // ----------------------------------------
    // reset and ship outputs
    // ----------------------------------------
    logic power_cycle_r;
    logic ship_r;
    logic soft_d_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_cycle_r <= 1'b0;
            ship_r <= 1'b0;
            soft_d_r <= 1'b0;
        end else begin
            power_cycle_r <= btn_reset || wd_fire
                || (soft_power_cycle_cmd_i && !soft_d_r);
            ship_r <= btn_ship;
            soft_d_r <= soft_power_cycle_cmd_i;
        end
    end

    assign power_cycle_o = power_cycle_r;
    assign ship_mode_o = ship_r;
    assign vdd_on_o = 1'b1;

    // ----------------------------------------
    // flags and interrupt pulses
    // ----------------------------------------
    logic [NS-1:0] flag_r;
    logic [NS-1:0] flag_nxt;
    logic [NS-1:0] cond;
    logic [NS-1:0] cond_d_r;
    logic [NS-1:0] rise;
    logic irq_ok_r;
    logic irq_trig;
    logic pulse_on;

    always_comb begin
        cond = '0;
        cond[brwi_pkg::SRC_CV] = status_i.const_voltage;
        cond[brwi_pkg::SRC_DONE] = status_i.charge_done;
        cond[brwi_pkg::SRC_IIN] = status_i.input_current_limit;
        cond[brwi_pkg::SRC_VIN] = status_i.input_voltage_loop;
        cond[brwi_pkg::SRC_THERM] = status_i.thermal_foldback;
        cond[brwi_pkg::SRC_WARN] = warn_evt;
        cond[brwi_pkg::SRC_WDOG] = wd_fire;
        rise = cond & ~cond_d_r;
        // set wins over the read-clear
        flag_nxt = (flag_read_i ? '0 : flag_r) | rise;
    end

    // button-sourced events only interrupt when their flag was clear or is being read in the same cycle
    always_comb begin
        irq_trig = 1'b0;
        for (int i = 0; i < NS; i++) begin
            if (rise[i] && !irq_mask_i[i]
                && !(i == brwi_pkg::SRC_WARN && flag_r[i] && !flag_read_i)) begin
                irq_trig = irq_ok_r;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_r <= '0;
            cond_d_r <= '0;
            irq_ok_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            cond_d_r <= cond;
            if (startup_done_i && !startup_fault_i) begin
                irq_ok_r <= 1'b1;
            end
        end
    end

    brwi_pulse #(.LEN(brwi_pkg::INT_PULSE_CYC)) u_pulse (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .trig_i(irq_trig),
        .active_o(pulse_on)
    );

    assign int_out_o = 1'b0;
    assign int_oe_b_o = !pulse_on;
    assign flags_o = flag_r;
    assign reset_warning_flag_o = flag_r[brwi_pkg::SRC_WARN];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_fire;
        lp_fire && reset_ok_nxt && long_press_action_sel_i == 2'h0;
    endsequence

    chk_reset_action: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_fire |=> power_cycle_o) else $error("long press reset missing");
    chk_ship_action: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (lp_fire && act_nxt == 2'h1) |=> ship_mode_o)
        else $error("ship action missing");
    chk_no_late_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pressed && !press_start && long_press_action_sel_i != 2'h0) |=> !reset_ok_r)
        else $error("reset allowed after switch");
    chk_vin_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pressed && reset_requires_input_i && !vin_valid_i) |=> !reset_ok_r)
        else $error("reset without input");
    chk_wd_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !adapter_watchdog_enable_i |=> !wd_run_r) else $error("watchdog armed");
    chk_wd_fire: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        wd_fire |=> power_cycle_o) else $error("watchdog reset missing");
    chk_pulse_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        irq_trig |=> !int_oe_b_o [*8]) else $error("interrupt pulse short");
    chk_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !irq_ok_r |-> !irq_trig) else $error("interrupt before start-up");
    chk_mask: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (irq_trig) |-> |(rise & ~irq_mask_i)) else $error("masked event pulsed");
    chk_count_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !pressed |=> cnt_r == '0) else $error("timer not cleared");
    chk_vdd_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        power_cycle_o |-> vdd_on_o) else $error("vdd dropped");
endmodule

// File: testbench.sv
// self-checking bench: long press, soft reset, watchdog, interrupt pulses
// assumes TICK_CYC of 4 and a watchdog of 1000 cycles to keep the run short
`timescale 1ns/1ps
module testbench;
    localparam int WD = 1000;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic btn = 1'b1, cmd = 1'b0, rq = 1'b0, vin = 1'b0, wen = 1'b0;
    logic sd = 1'b0, sf = 1'b0, wk = 1'b0, kick = 1'b0, rd = 1'b0, w;
    logic [1:0] sel = 2'h0;
    logic [15:0] lpt = 16'h000a, lead = 16'h0002;
    logic [4:0] st = 5'h00;
    logic [6:0] msk = 7'h7f;
    logic [6:0] flg;
    logic warn, pc_o, sh_o, vdd, iout, ioe, bus, frd;
    logic [7:0] irqs;
    wire int_n = ioe ? 1'b1 : iout;
    int fails = 0, compares = 0;
    int pc, sh, at, t, r, b;
    always #4 clk_i = ~clk_i;
    brwi_top #(.WDOG_CYCLES(64'(WD)), .TICK_CYC(4)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .pushbutton_in_n_i(btn), .long_press_action_sel_i(sel), .long_press_time_i(lpt),
        .warning_lead_time_i(lead), .reset_requires_input_i(rq), .vin_valid_i(vin),
        .soft_power_cycle_cmd_i(cmd), .adapter_watchdog_enable_i(wen),
        .bus_transaction_i(bus), .startup_done_i(sd), .startup_fault_i(sf),
        .ship_wake_i(wk), .status_i(brwi_pkg::brwi_status_s'(st)), .irq_mask_i(msk),
        .flag_read_i(frd), .reset_warning_flag_o(warn), .flags_o(flg),
        .power_cycle_o(pc_o), .ship_mode_o(sh_o), .vdd_on_o(vdd), .int_out_o(iout),
        .int_oe_b_o(ioe));
    brwi_host_model host (.clk_i(clk_i), .rst_b_i(rst_b_i), .int_n_i(int_n),
        .auto_kick_i(kick), .read_req_i(rd), .bus_transaction_o(bus),
        .flag_read_o(frd), .irq_count_o(irqs));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    function automatic logic in_win(input int a, input int tk);
        return a >= 4 * tk - 4 && a <= 4 * tk + 8;
    endfunction
    // counts action pulses; w notes a warning seen before the first one
    task automatic watch(input int n);
        pc = 0;
        sh = 0;
        at = -1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            if (vdd !== 1'b1) chk(1'b0, "core supply dropped");
            if (at < 0 && warn === 1'b1) w = 1'b1;
            if (at < 0 && (pc_o === 1'b1 || sh_o === 1'b1)) at = i;
            pc += int'(pc_o === 1'b1);
            sh += int'(sh_o === 1'b1);
        end
    endtask
    task automatic press(input int n);
        @(posedge clk_i);
        btn <= 1'b0;
        watch(n);
        @(posedge clk_i);
        btn <= 1'b1;
        cyc(12);
    endtask
    task automatic rdflags();
        @(posedge clk_i);
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        cyc(3);
    endtask
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_i);
        chk(1'b0, "run timeout");
        finish_test();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'hf7832a29));
        cyc(2);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        chk(flg === 7'h00 && ioe === 1'b1 && pc_o === 1'b0, "reset state");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            sel <= 2'(s);
            t = 6 + int'($urandom % 8);
            lpt <= 16'(t);
            lead <= 16'(1 + ($urandom % 4));
            rdflags();
            w = 1'b0;
            press(4 * t + 40);
            chk(pc == int'(s == 0) && sh == int'(s == 1), "action select");
            chk(pc + sh == 0 || in_win(at, t), "action timing");
            chk(w === 1'b1, "warning before expiry");
        end
        sel <= 2'h0;
        press(4 * t - 12);
        chk(pc == 0, "early release");
        press(4 * t + 20);
        chk(pc == 1 && in_win(at, t), "count restarts");
        fork press(4 * t + 20); begin cyc(8); sel <= 2'h2; end join
        chk(pc + sh == 0, "abort by new select");
        sel <= 2'h1;
        fork press(4 * t + 20); begin cyc(8); sel <= 2'h0; end join
        chk(pc == 0 && sh == 1, "late switch to reset");
        rq <= 1'b1;
        vin <= 1'b1;
        fork press(4 * t + 20); begin cyc(8); vin <= 1'b0; cyc(2); vin <= 1'b1; end join
        chk(pc == 0, "input lost mid press");
        press(4 * t + 20);
        chk(pc == 1, "input kept whole press");
        rq <= 1'b0;
        fork press(4 * t + 20); begin cyc(8); lpt <= 16'(t + 20); end join
        chk(pc == 1 && in_win(at, t), "old duration kept");
        lpt <= 16'(t);
        fork press(4 * t + 20); begin cyc(8); wk <= 1'b1; cyc(1); wk <= 1'b0; end join
        chk(pc == 0, "held after wake");
        press(4 * t + 60);
        chk(pc == 1, "re-press after wake");
        cmd <= 1'b1;
        watch(6);
        chk(pc == 1, "soft power cycle");
        cyc(1);
        cmd <= 1'b0;
        vin <= 1'b0;
        cyc(2);
        vin <= 1'b1;
        watch(WD + 200);
        chk(pc == 0, "watchdog off after reset");
        cyc(1);
        vin <= 1'b0;
        wen <= 1'b1;
        cyc(2);
        vin <= 1'b1;
        watch(WD + 100);
        chk(pc == 1 && at >= WD - 10 && at <= WD + 10 && flg[6] === 1'b1, "watchdog");
        cyc(1);
        vin <= 1'b0;
        kick <= 1'b1;
        cyc(2);
        vin <= 1'b1;
        watch(3 * WD / 2);
        chk(pc == 0, "watchdog kicked");
        cyc(1);
        kick <= 1'b0;
        wen <= 1'b0;
        rdflags();
        sd <= 1'b1;
        sf <= 1'b1;
        msk <= 7'h00;
        cyc(2);
        st <= 5'h10;
        cyc(4);
        chk(flg[0] === 1'b1 && irqs === 8'h00, "faulted start silent");
        st <= 5'h00;
        sf <= 1'b0;
        msk <= 7'h7f;
        rdflags();
        r = int'($urandom % 5);
        for (int i = 0; i < 5; i++) begin
            b = (r + i) % 5;
            st[b] <= 1'b1;
            cyc(3);
            chk(flg[4 - b] === 1'b1 && irqs === 8'h00, "masked flag");
        end
        msk <= 7'h00;
        cyc(4);
        chk(irqs === 8'h00, "unmask keeps quiet");
        msk <= 7'h7f;
        st <= 5'h00;
        rdflags();
        chk(flg === 7'h00, "flags cleared by read");
        msk <= 7'h6f;
        cyc(2);
        st <= 5'h01;
        t = 0;
        for (int i = 0; i < 17000; i++) begin
            @(negedge clk_i);
            t += int'(int_n === 1'b0);
        end
        chk(t == 16000 && irqs === 8'h01, "pulse width");
        cyc(1);
        st <= 5'h00;
        msk <= 7'h5f;
        sel <= 2'h2;
        t = int'(lpt);
        rdflags();
        press(4 * t + 20);
        chk(irqs === 8'h02 && warn === 1'b1, "warning interrupt");
        cyc(16100);
        press(4 * t + 20);
        chk(irqs === 8'h02 && warn === 1'b1, "no repeat before read");
        rdflags();
        chk(warn === 1'b0, "warning cleared");
        finish_test();
    end
endmodule
